// file: hw/baud_divisor_extended_control.sv
/*
  Bank 1 / bank 2 register logic: divisor ports, legacy fallback, extended
  control registers, DMA request routing and the baud generator.
  Assumes a byte-wide synchronous host bus with one-cycle read and write
  strobes that never come together, and a datapath that owns the queues,
  the modem control and infrared control registers.
*/
// What this block does
// - Bank 2 offsets 0 and 1 give a second path to the divisor bytes.
// - Legacy divisor access in extended mode falls back and clears listed control bits.
// - Non-extended, unlocked legacy access clears control one bits 5,7 and two bits 0-5.
// - Non-extended, locked legacy access leaves divisor and all modes untouched.
// - Divisor low byte at the lower offset, high byte at the next.
// - Writing either divisor byte reloads the baud counter at once.
// - Divisor holds the reload value; counter restarts from it each period.
// - Bank 2 decodes offsets 0-4, 6, 7; offset 5 reserved.
// - Extended control one resets to all zeros.
// - The extended select bit at one puts the device in extended mode.
// - Fairness zero cuts DMA requests after about 10.5 us continuous activity.
// - Fairness one holds transmit request until full, receive until empty.
// - Transmit request below threshold; receive request at threshold or timeout.
// - Threshold bit picks receive 4/10 and transmit 13,29 / 7,23.
// - Swap bit exchanges transmit and receive request and acknowledge paths.
// - Outside extended mode, lock bit redirects legacy divisor offsets to two scratchpads, no fallback.
// - Prescaler divides by 13, 1.625 or 1; code 10 reserved.
// - Echo path bit selects internal loopback.
// - Probe bit drives the baud generator output onto the DTR pin.
`timescale 1ns/1ps
module baud_divisor_extended_control (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] DATA_I,
  input wire logic RD_I,
  input wire logic WR_I,
  input wire logic [5:0] SEND_QUEUE_LEVEL_I,
  input wire logic [5:0] RECEIVE_QUEUE_LEVEL_I,
  input wire logic RX_TIMEOUT_I,
  input wire logic MODEM_DTR_I,
  input wire logic DMA_ACK_A_I,
  input wire logic DMA_ACK_B_I,
  output logic [7:0] DATA_O,
  output logic DMA_REQ_A_O,
  output logic DMA_REQ_B_O,
  output logic TX_DMA_ACK_O,
  output logic RX_DMA_ACK_O,
  output logic DTR_O,
  output logic BAUD_TICK_O,
  output logic EXTENDED_MODE_O,
  output logic LOOPBACK_O,
  output logic ECHO_TX_O,
  output logic TX_QUEUE_DEEP_O,
  output logic RX_QUEUE_DEEP_O,
  output logic FALLBACK_CLEAR_O,
  output logic [7:0] LINE_CONTROL_O
);

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] ext_one;
    logic [7:0] ext_two;
    logic [7:0] bank_sel;
    logic [7:0] line_ctl;
    logic [7:0] scratch_low;
    logic [7:0] scratch_high;
    logic [7:0] rdata;
    logic div_load;
    logic fallback_clear;
    logic dtr;
    logic tx_deep;
    logic rx_deep;
  } regs_s;

  regs_s s;
  regs_s next_s;
  baud_bank_pkg::bank_e bank;
  logic access;
  logic div_offset;
  logic ext_mode;
  logic locked;
  logic legacy_hit;
  logic legacy_to_div;
  logic legacy_to_scratch;
  logic direct_div;
  logic baud_tick;
  logic req_a;
  logic req_b;
  logic tx_ack;
  logic rx_ack;

  // Bit 7 clear selects the legacy bank; one fixed code selects bank 2
  function automatic baud_bank_pkg::bank_e bank_of(input logic [7:0] sel);
    if (!sel[baud_bank_pkg::BANK_SEL_BIT]) begin
      bank_of = baud_bank_pkg::BANK_LEGACY;
    end else if (sel == baud_bank_pkg::BANK_TWO_CODE) begin
      bank_of = baud_bank_pkg::BANK_TWO;
    end else begin
      bank_of = baud_bank_pkg::BANK_ONE;
    end
  endfunction

  // Address decode shared by the read and write paths
  always_comb begin
    bank = bank_of(s.bank_sel);
    access = RD_I || WR_I;
    div_offset = (ADDR_I == baud_bank_pkg::OFF_DIV_LOW) || (ADDR_I == baud_bank_pkg::OFF_DIV_HIGH);
    ext_mode = s.ext_one[baud_bank_pkg::EXT_SEL_BIT];
    locked = s.ext_two[baud_bank_pkg::LOCK_BIT];
    legacy_hit = access && (bank == baud_bank_pkg::BANK_ONE) && div_offset;
    // Lock only counts outside extended mode; software must clear it there
    legacy_to_div = legacy_hit && (ext_mode || !locked);
    legacy_to_scratch = legacy_hit && !ext_mode && locked;
    direct_div = access && (bank == baud_bank_pkg::BANK_TWO) && div_offset;
  end

  // Register writes, fallback clearing and read data capture
  always_comb begin
    next_s = s;
    next_s.div_load = 1'b0;
    next_s.fallback_clear = 1'b0;
    next_s.dtr = s.ext_one[baud_bank_pkg::PROBE_BIT] ? baud_tick : MODEM_DTR_I;
    if (WR_I) begin
      if (legacy_to_div || direct_div) begin
        if (ADDR_I == baud_bank_pkg::OFF_DIV_LOW) begin
          next_s.divisor[7:0] = DATA_I;
        end else begin
          next_s.divisor[15:8] = DATA_I;
        end
        next_s.div_load = 1'b1;
      end
      if (legacy_to_scratch) begin
        if (ADDR_I == baud_bank_pkg::OFF_DIV_LOW) begin
          next_s.scratch_low = DATA_I;
        end else begin
          next_s.scratch_high = DATA_I;
        end
      end
      if (bank == baud_bank_pkg::BANK_TWO && ADDR_I == baud_bank_pkg::OFF_EXT_ONE) begin
        next_s.ext_one = DATA_I;
      end
      if (bank == baud_bank_pkg::BANK_TWO && ADDR_I == baud_bank_pkg::OFF_EXT_TWO) begin
        next_s.ext_two = DATA_I;
      end
      // Offset 3 is common to every bank; bit 7 clear also loads line control
      if (ADDR_I == baud_bank_pkg::OFF_LINE_CONTROL_BANK_SELECT) begin
        next_s.bank_sel = DATA_I;
        if (!DATA_I[baud_bank_pkg::BANK_SEL_BIT]) begin
          next_s.line_ctl = DATA_I;
        end
      end
    end
    // Reads as well as writes of the legacy divisor trigger the fallback
    if (legacy_to_div) begin
      if (ext_mode) begin
        next_s.ext_one = s.ext_one & baud_bank_pkg::EXT_ONE_FALLBACK_KEEP;
        next_s.fallback_clear = 1'b1;
      end else begin
        next_s.ext_one = s.ext_one & baud_bank_pkg::EXT_ONE_LEGACY_KEEP;
      end
      next_s.ext_two = s.ext_two & baud_bank_pkg::EXT_TWO_FALLBACK_KEEP;
    end
    if (RD_I) begin
      next_s.rdata = 8'h00;
      case (ADDR_I)
        baud_bank_pkg::OFF_DIV_LOW: begin
          if (legacy_to_scratch) begin
            next_s.rdata = s.scratch_low;
          end else if (legacy_to_div || direct_div) begin
            next_s.rdata = s.divisor[7:0];
          end
        end
        baud_bank_pkg::OFF_DIV_HIGH: begin
          if (legacy_to_scratch) begin
            next_s.rdata = s.scratch_high;
          end else if (legacy_to_div || direct_div) begin
            next_s.rdata = s.divisor[15:8];
          end
        end
        baud_bank_pkg::OFF_EXT_ONE: begin
          if (bank == baud_bank_pkg::BANK_TWO) begin
            next_s.rdata = s.ext_one & baud_bank_pkg::EXT_ONE_READ_MASK;
          end
        end
        baud_bank_pkg::OFF_LINE_CONTROL_BANK_SELECT: begin
          next_s.rdata = s.bank_sel;
        end
        baud_bank_pkg::OFF_EXT_TWO: begin
          if (bank == baud_bank_pkg::BANK_TWO) begin
            next_s.rdata = s.ext_two & baud_bank_pkg::EXT_TWO_READ_MASK;
          end
        end
        baud_bank_pkg::OFF_SEND_LVL: begin
          if (bank == baud_bank_pkg::BANK_TWO) begin
            next_s.rdata = {2'b00, SEND_QUEUE_LEVEL_I};
          end
        end
        baud_bank_pkg::OFF_RECV_LVL: begin
          if (bank == baud_bank_pkg::BANK_TWO) begin
            next_s.rdata = {2'b00, RECEIVE_QUEUE_LEVEL_I};
          end
        end
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Depth flags kept as flops so the outputs need no decode after the register
    next_s.tx_deep = next_s.ext_two[baud_bank_pkg::TX_SIZE_LSB +: 2]
      == baud_bank_pkg::SIZE_DEEP_CODE;
    next_s.rx_deep = next_s.ext_two[baud_bank_pkg::RX_SIZE_LSB +: 2]
      == baud_bank_pkg::SIZE_DEEP_CODE;
  end

  // State register; the divisor gets a constant since its true value is undefined
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s.divisor <= baud_bank_pkg::DIV_RESET;
      s.ext_one <= baud_bank_pkg::EXT_ONE_RESET;
      s.ext_two <= baud_bank_pkg::EXT_TWO_RESET;
      s.bank_sel <= baud_bank_pkg::BANK_SEL_RESET;
      s.line_ctl <= baud_bank_pkg::LINE_CTL_RESET;
      s.scratch_low <= baud_bank_pkg::SCRATCH_RESET;
      s.scratch_high <= baud_bank_pkg::SCRATCH_RESET;
      s.rdata <= 8'h00;
      s.div_load <= 1'b0;
      s.fallback_clear <= 1'b0;
      s.dtr <= 1'b0;
      s.tx_deep <= 1'b0;
      s.rx_deep <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Baud generator, reloaded on every divisor write
  baud_rate_counter baud_gen (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .divisor_i(s.divisor),
    .load_i(s.div_load),
    .prescale_code_i(s.ext_two[baud_bank_pkg::PRESCALE_LSB +: 2]),
    .baud_tick_o(baud_tick)
  );

  // DMA request logic; sizes 1x are reserved and act as shallow
  dma_request_logic dma_req (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .tx_level_i(SEND_QUEUE_LEVEL_I),
    .rx_level_i(RECEIVE_QUEUE_LEVEL_I),
    .tx_deep_i(s.ext_two[baud_bank_pkg::TX_SIZE_LSB +: 2] == baud_bank_pkg::SIZE_DEEP_CODE),
    .rx_deep_i(s.ext_two[baud_bank_pkg::RX_SIZE_LSB +: 2] == baud_bank_pkg::SIZE_DEEP_CODE),
    .rx_timeout_i(RX_TIMEOUT_I),
    .fairness_i(s.ext_one[baud_bank_pkg::FAIR_BIT]),
    .threshold_i(s.ext_one[baud_bank_pkg::THR_BIT]),
    .swap_i(s.ext_one[baud_bank_pkg::SWAP_BIT]),
    .ack_a_i(DMA_ACK_A_I),
    .ack_b_i(DMA_ACK_B_I),
    .req_a_o(req_a),
    .req_b_o(req_b),
    .tx_ack_o(tx_ack),
    .rx_ack_o(rx_ack)
  );

  // Outputs, each a flip-flop in this module or a submodule
  assign DATA_O = s.rdata;
  assign DMA_REQ_A_O = req_a;
  assign DMA_REQ_B_O = req_b;
  assign TX_DMA_ACK_O = tx_ack;
  assign RX_DMA_ACK_O = rx_ack;
  assign DTR_O = s.dtr;
  assign BAUD_TICK_O = baud_tick;
  assign EXTENDED_MODE_O = s.ext_one[baud_bank_pkg::EXT_SEL_BIT];
  assign LOOPBACK_O = s.ext_one[baud_bank_pkg::ECHO_PATH_BIT];
  assign ECHO_TX_O = s.ext_one[baud_bank_pkg::ECHO_TX_BIT];
  assign TX_QUEUE_DEEP_O = s.tx_deep;
  assign RX_QUEUE_DEEP_O = s.rx_deep;
  assign FALLBACK_CLEAR_O = s.fallback_clear;
  assign LINE_CONTROL_O = s.line_ctl;

  a_fallback_clear: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (legacy_hit && ext_mode) |=> (!EXTENDED_MODE_O && FALLBACK_CLEAR_O
      && s.ext_two[5:0] == 6'h00 && !s.ext_one[5] && !s.ext_one[7]))
    else $error("fallback did not clear the extended bits");

  a_legacy_clear: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (legacy_hit && !ext_mode && !locked) |=> (!FALLBACK_CLEAR_O && !s.ext_one[5]
      && !s.ext_one[7] && s.ext_two[5:0] == 6'h00 && !EXTENDED_MODE_O))
    else $error("unlocked legacy access did not clear bits");

  a_lock_keeps: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (legacy_hit && !ext_mode && locked) |=> ($stable(s.divisor) && $stable(s.ext_one)
      && $stable(s.ext_two) && !s.div_load))
    else $error("locked legacy access changed state");

  a_scratch_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (WR_I && legacy_to_scratch && ADDR_I == baud_bank_pkg::OFF_DIV_HIGH)
      |=> s.scratch_high == $past(DATA_I))
    else $error("scratchpad not written");

  a_div_low_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (WR_I && direct_div && ADDR_I == baud_bank_pkg::OFF_DIV_LOW)
      |=> (s.divisor[7:0] == $past(DATA_I) && $stable(s.divisor[15:8]) && s.div_load))
    else $error("divisor low byte write wrong");

  a_ext_select: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (WR_I && bank == baud_bank_pkg::BANK_TWO && ADDR_I == baud_bank_pkg::OFF_EXT_ONE)
      |=> EXTENDED_MODE_O == $past(DATA_I[0]))
    else $error("extended select not taken");

  a_level_read: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (RD_I && bank == baud_bank_pkg::BANK_TWO && ADDR_I == baud_bank_pkg::OFF_SEND_LVL)
      |=> DATA_O == {2'b00, $past(SEND_QUEUE_LEVEL_I)})
    else $error("send queue level read wrong");

  a_reserved_read: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (RD_I && ADDR_I == baud_bank_pkg::OFF_RESERVED) |=> DATA_O == 8'h00)
    else $error("reserved offset read not zero");

  a_probe_route: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    s.ext_one[baud_bank_pkg::PROBE_BIT] |=> DTR_O == $past(baud_tick))
    else $error("probe did not route baud output to DTR");

  a_legacy_div_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (WR_I && legacy_to_div && ADDR_I == baud_bank_pkg::OFF_DIV_HIGH)
      |=> (s.divisor[15:8] == $past(DATA_I) && s.div_load))
    else $error("legacy divisor high byte write lost");

  a_legacy_div_read: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (RD_I && legacy_to_div && ADDR_I == baud_bank_pkg::OFF_DIV_HIGH)
      |=> DATA_O == $past(s.divisor[15:8]))
    else $error("legacy divisor high byte read wrong");

  a_fallback_pulse: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    FALLBACK_CLEAR_O |=> !FALLBACK_CLEAR_O)
    else $error("fallback clear pulse longer than one cycle");

endmodule

// file: hw/baud_bank_pkg.sv
/*
  Shared constants for the bank 1 / bank 2 register logic of the serial
  controller: offsets, field positions, reset values, masks and timing counts.
  Assumes a single 25 MHz system clock, from which all slower rates are enables.
*/
package baud_bank_pkg;

  // Register offsets inside a bank
  localparam logic [2:0] OFF_DIV_LOW = 3'h0;
  localparam logic [2:0] OFF_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFF_EXT_ONE = 3'h2;
  localparam logic [2:0] OFF_LINE_CONTROL_BANK_SELECT = 3'h3;
  localparam logic [2:0] OFF_EXT_TWO = 3'h4;
  localparam logic [2:0] OFF_RESERVED = 3'h5;
  localparam logic [2:0] OFF_SEND_LVL = 3'h6;
  localparam logic [2:0] OFF_RECV_LVL = 3'h7;

  // Bank selection by the byte last written at offset 3
  typedef enum logic [1:0] {BANK_LEGACY, BANK_ONE, BANK_TWO} bank_e;
  localparam logic [7:0] BANK_TWO_CODE = 8'he0;
  localparam int BANK_SEL_BIT = 7;

  // Extended control one fields
  localparam int EXT_SEL_BIT = 0;
  localparam int FAIR_BIT = 1;
  localparam int THR_BIT = 2;
  localparam int SWAP_BIT = 3;
  localparam int ECHO_PATH_BIT = 4;
  localparam int ECHO_TX_BIT = 5;
  localparam int PROBE_BIT = 7;

  // Extended control two fields
  localparam int TX_SIZE_LSB = 0;
  localparam int RX_SIZE_LSB = 2;
  localparam int PRESCALE_LSB = 4;
  localparam int LOCK_BIT = 7;
  localparam logic [1:0] SIZE_DEEP_CODE = 2'h1;

  // Reset values
  localparam logic [7:0] EXT_ONE_RESET = 8'h00;
  localparam logic [7:0] EXT_TWO_RESET = 8'h00;
  localparam logic [7:0] BANK_SEL_RESET = 8'h00;
  localparam logic [7:0] LINE_CTL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;

  // Keep masks applied on a legacy divisor access, and read masks
  localparam logic [7:0] EXT_ONE_FALLBACK_KEEP = 8'h5e;
  localparam logic [7:0] EXT_ONE_LEGACY_KEEP = 8'h5f;
  localparam logic [7:0] EXT_TWO_FALLBACK_KEEP = 8'hc0;
  localparam logic [7:0] EXT_ONE_READ_MASK = 8'hbf;
  localparam logic [7:0] EXT_TWO_READ_MASK = 8'hbf;

  // DMA thresholds and queue depths
  localparam logic [5:0] RX_THR_LOW = 6'h04;
  localparam logic [5:0] RX_THR_HIGH = 6'h0a;
  localparam logic [5:0] TX_THR_SHALLOW_LOW = 6'h0d;
  localparam logic [5:0] TX_THR_DEEP_LOW = 6'h1d;
  localparam logic [5:0] TX_THR_SHALLOW_HIGH = 6'h07;
  localparam logic [5:0] TX_THR_DEEP_HIGH = 6'h17;
  localparam logic [5:0] DEPTH_SHALLOW = 6'h10;
  localparam logic [5:0] DEPTH_DEEP = 6'h20;

  // Timing: burst cut rounds down, being a longest time
  localparam int CLK_PERIOD_NS = 40;
  localparam int DMA_BURST_NS = 10500;
  localparam logic [8:0] DMA_BURST_CYCLES = 9'(DMA_BURST_NS / CLK_PERIOD_NS);

  // Prescaler: fractional accumulator modulo 13, step picks the ratio
  localparam logic [4:0] PRESCALE_MOD = 5'h0d;
  localparam logic [1:0] PRESCALE_CODE_13 = 2'h0;
  localparam logic [1:0] PRESCALE_CODE_1625 = 2'h1;
  localparam logic [1:0] PRESCALE_CODE_1 = 2'h3;
  localparam logic [4:0] STEP_DIV_13 = 5'h01;
  localparam logic [4:0] STEP_DIV_1625 = 5'h08;
  localparam logic [4:0] STEP_DIV_1 = 5'h0d;

endpackage

// file: hw/baud_rate_counter.sv
/*
  Prescaler and 16-bit baud generator counter.
  Assumes the divisor input is a register that changes on the same edge as load.
*/
`timescale 1ns/1ps
module baud_rate_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] divisor_i,
  input wire logic load_i,
  input wire logic [1:0] prescale_code_i,
  output logic baud_tick_o
);

  typedef struct packed {
    logic [3:0] acc;
    logic [15:0] count;
    logic tick;
  } baud_s;

  baud_s s;
  baud_s next_s;
  logic [4:0] step;
  logic [4:0] sum;
  logic pre_tick;

  // Fractional prescale: 1/13, 8/13 or every cycle; reserved code acts as 13
  always_comb begin
    case (prescale_code_i)
      baud_bank_pkg::PRESCALE_CODE_13: step = baud_bank_pkg::STEP_DIV_13;
      baud_bank_pkg::PRESCALE_CODE_1625: step = baud_bank_pkg::STEP_DIV_1625;
      baud_bank_pkg::PRESCALE_CODE_1: step = baud_bank_pkg::STEP_DIV_1;
      default: step = baud_bank_pkg::STEP_DIV_13;
    endcase
    sum = {1'b0, s.acc} + step;
    pre_tick = (sum >= baud_bank_pkg::PRESCALE_MOD);
    next_s = s;
    next_s.tick = 1'b0;
    next_s.acc = pre_tick ? 4'(sum - baud_bank_pkg::PRESCALE_MOD) : sum[3:0];
    // A divisor write restarts the count at once
    if (load_i) begin
      next_s.count = divisor_i;
    end else if (pre_tick) begin
      if (s.count <= 16'h0001) begin
        next_s.count = divisor_i;
        next_s.tick = 1'b1;
      end else begin
        next_s.count = 16'(s.count - 16'h0001);
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign baud_tick_o = s.tick;

  a_div_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i |=> (s.count == $past(divisor_i)))
    else $error("divisor write did not reload the counter");

  a_tick_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (pre_tick && !load_i && s.count > 16'h0001) |=> !s.tick)
    else $error("tick before the count expired");

endmodule

// file: hw/dma_request_logic.sv
/*
  DMA request generation with thresholds, fairness and channel exchange.
  Assumes queue levels come from the datapath, synchronous to the clock.
*/
`timescale 1ns/1ps
module dma_request_logic (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] tx_level_i,
  input wire logic [5:0] rx_level_i,
  input wire logic tx_deep_i,
  input wire logic rx_deep_i,
  input wire logic rx_timeout_i,
  input wire logic fairness_i,
  input wire logic threshold_i,
  input wire logic swap_i,
  input wire logic ack_a_i,
  input wire logic ack_b_i,
  output logic req_a_o,
  output logic req_b_o,
  output logic tx_ack_o,
  output logic rx_ack_o
);

  typedef struct packed {
    logic tx_req;
    logic rx_req;
    logic [8:0] burst;
    logic req_a;
    logic req_b;
    logic tx_ack;
    logic rx_ack;
  } dma_s;

  dma_s s;
  dma_s next_s;
  logic [5:0] tx_thr;
  logic [5:0] rx_thr;
  logic [5:0] tx_depth;
  logic [5:0] rx_depth;
  logic tx_cond;
  logic rx_cond;

  function automatic logic [5:0] tx_threshold(input logic thr, input logic deep);
    if (thr) begin
      tx_threshold = deep ? baud_bank_pkg::TX_THR_DEEP_HIGH : baud_bank_pkg::TX_THR_SHALLOW_HIGH;
    end else begin
      tx_threshold = deep ? baud_bank_pkg::TX_THR_DEEP_LOW : baud_bank_pkg::TX_THR_SHALLOW_LOW;
    end
  endfunction

  // Requests in the unswapped frame, then routed
  always_comb begin
    tx_thr = tx_threshold(threshold_i, tx_deep_i);
    rx_thr = threshold_i ? baud_bank_pkg::RX_THR_HIGH : baud_bank_pkg::RX_THR_LOW;
    tx_depth = tx_deep_i ? baud_bank_pkg::DEPTH_DEEP : baud_bank_pkg::DEPTH_SHALLOW;
    rx_depth = rx_deep_i ? baud_bank_pkg::DEPTH_DEEP : baud_bank_pkg::DEPTH_SHALLOW;
    tx_cond = (tx_level_i < tx_thr);
    rx_cond = (rx_level_i >= rx_thr) || rx_timeout_i;
    next_s = s;
    if (fairness_i) begin
      // Hold until full or empty; the rx depth term is never zero, so only an empty level ends it
      next_s.tx_req = s.tx_req ? (tx_level_i < tx_depth) : tx_cond;
      next_s.rx_req = s.rx_req ? (rx_level_i != 6'h00 && rx_depth != 6'h00) : rx_cond;
      next_s.burst = 9'h000;
    end else if (s.burst >= baud_bank_pkg::DMA_BURST_CYCLES) begin
      // Cut the burst so other bus masters get a turn
      next_s.tx_req = 1'b0;
      next_s.rx_req = 1'b0;
      next_s.burst = 9'h000;
    end else begin
      next_s.tx_req = tx_cond;
      next_s.rx_req = rx_cond;
      next_s.burst = (s.tx_req || s.rx_req) ? 9'(s.burst + 9'h001) : 9'h000;
    end
    next_s.req_a = swap_i ? next_s.rx_req : next_s.tx_req;
    next_s.req_b = swap_i ? next_s.tx_req : next_s.rx_req;
    next_s.tx_ack = swap_i ? ack_b_i : ack_a_i;
    next_s.rx_ack = swap_i ? ack_a_i : ack_b_i;
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign req_a_o = s.req_a;
  assign req_b_o = s.req_b;
  assign tx_ack_o = s.tx_ack;
  assign rx_ack_o = s.rx_ack;

  a_burst_cut: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fairness_i && s.burst >= baud_bank_pkg::DMA_BURST_CYCLES) |=> (!s.tx_req && !s.rx_req))
    else $error("DMA burst not cut at the limit");

  a_swap_route: assert property (@(posedge clk_i) disable iff (rst_i)
    s.req_a == ($past(swap_i) ? s.rx_req : s.tx_req))
    else $error("DMA request routing wrong");

  a_fair_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (fairness_i && s.tx_req && tx_level_i < tx_depth) |=> s.tx_req)
    else $error("transmit request dropped before queue full");

endmodule

// file: tb/dma_partner.sv
/* DMA controller model beside the request pins.
   Assumes level requests sampled on the rising clock edge. */
`timescale 1ns/1ps
module dma_partner (
  input wire logic clk_i,
  input wire logic req_a_i,
  input wire logic req_b_i,
  output logic ack_a_o = 1'b0,
  output logic ack_b_o = 1'b0
);
  // Acks trail requests by a cycle, like a demand-mode channel
  always @(posedge clk_i) begin
    ack_a_o <= #1 req_a_i;
    ack_b_o <= #1 req_b_i;
  end
endmodule

// file: tb/baud_divisor_extended_control_tb_top.sv
/* Self-checking bench for the divisor and extended control registers.
   Assumes one-cycle strobes and the DMA partner model. */
`timescale 1ns/1ps
module baud_divisor_extended_control_tb_top;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, rto = 1'b0, mdtr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdat = 8'h00, dout, d;
  logic [5:0] slvl = 6'h00, rlvl = 6'h00;
  logic ack_a, ack_b, req_a, req_b, tx_ack, rx_ack, tick, ext, fb, f, lp, etx, deep, dtr;
  int failures = 0, samples_checked = 0, n;
  // Clock, 40 ns period
  always #20 clk = ~clk;
  baud_divisor_extended_control u_baud_divisor_extended_control (.SYS_CLK_I(clk),
    .SYS_RST_I(rst), .ADDR_I(addr), .DATA_I(wdat), .RD_I(rd), .WR_I(wr),
    .SEND_QUEUE_LEVEL_I(slvl), .RECEIVE_QUEUE_LEVEL_I(rlvl), .RX_TIMEOUT_I(rto),
    .MODEM_DTR_I(mdtr), .DMA_ACK_A_I(ack_a), .DMA_ACK_B_I(ack_b), .DATA_O(dout),
    .DMA_REQ_A_O(req_a), .DMA_REQ_B_O(req_b), .TX_DMA_ACK_O(tx_ack),
    .RX_DMA_ACK_O(rx_ack), .DTR_O(dtr), .BAUD_TICK_O(tick), .EXTENDED_MODE_O(ext),
    .LOOPBACK_O(lp), .ECHO_TX_O(etx), .TX_QUEUE_DEEP_O(deep), .RX_QUEUE_DEEP_O(),
    .FALLBACK_CLEAR_O(fb), .LINE_CONTROL_O());
  dma_partner u_dma_partner (.clk_i(clk), .req_a_i(req_a), .req_b_i(req_b),
    .ack_a_o(ack_a), .ack_b_o(ack_b));
  // Verdict and compare helpers
  task automatic close_out();
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles: strobe held for exactly one edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) #1 addr = a;
    wdat = v;
    wr = 1'b1;
    @(posedge clk) #1 wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk) #1 addr = a;
    rd = 1'b1;
    @(posedge clk) #1 rd = 1'b0;
    d = dout;
    f = fb;
  endtask
  task automatic wait_tick(input int lim);
    n = 0;
    do begin @(posedge clk) #1 n++; end while (tick !== 1'b1 && n < lim);
  endtask
  // Scenarios
  task automatic t_baud();
    wr_reg(3'h3, 8'he0);
    rd_reg(3'h2); chk(d, 8'h00);
    wr_reg(3'h4, 8'h30);
    wr_reg(3'h0, 8'h04);
    wr_reg(3'h1, 8'h01);
    wr_reg(3'h1, 8'h00);
    wait_tick(8); chk(tick, 1'b1);
    wait_tick(20); chk(n, 4);
    rd_reg(3'h0); chk(d, 8'h04);
  endtask
  task automatic t_fallback();
    wr_reg(3'h2, 8'ha1);
    chk({ext, etx}, 2'h3);
    wr_reg(3'h4, 8'h3f);
    wr_reg(3'h3, 8'h80);
    rd_reg(3'h0); chk(d, 8'h04); chk(f, 1'b1); chk(ext, 1'b0);
    wr_reg(3'h3, 8'he0);
    rd_reg(3'h2); chk(d, 8'h00);
    rd_reg(3'h4); chk(d, 8'h00);
  endtask
  task automatic t_legacy();
    wr_reg(3'h2, 8'h90);
    wr_reg(3'h4, 8'h35);
    chk(deep, 1'b1);
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h1, 8'h02);
    rd_reg(3'h1); chk(d, 8'h02); chk(f, 1'b0);
    wr_reg(3'h3, 8'he0);
    rd_reg(3'h2); chk(d, 8'h10);
    chk(lp, 1'b1);
    rd_reg(3'h4); chk(d, 8'h00);
    wr_reg(3'h4, 8'h80);
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h0, 8'h5a);
    wr_reg(3'h1, 8'ha5);
    rd_reg(3'h0); chk(d, 8'h5a);
    rd_reg(3'h1); chk(d, 8'ha5);
    wr_reg(3'h3, 8'he0);
    rd_reg(3'h0); chk(d, 8'h04);
    rd_reg(3'h1); chk(d, 8'h02);
    rd_reg(3'h2); chk(d, 8'h10);
  endtask
  task automatic t_dma();
    mdtr = 1'b1;
    wr_reg(3'h4, 8'h00);
    slvl = 6'h05;
    repeat (3) @(posedge clk);
    #1 chk({req_a, tx_ack, dtr}, 3'h7);
    slvl = 6'h0d;
    rlvl = 6'h04;
    repeat (3) @(posedge clk);
    #1 chk({req_a, req_b, rx_ack}, 3'h3);
    rd_reg(3'h7); chk(d, 8'h04);
    rd_reg(3'h6); chk(d, 8'h0d);
    rd_reg(3'h5); chk(d, 8'h00);
    // Receive request now held up by the timeout alone
    rlvl = 6'h00;
    rto = 1'b1;
    wr_reg(3'h2, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk({req_a, req_b}, 2'h2);
    rto = 1'b0;
    wr_reg(3'h2, 8'h00);
    slvl = 6'h00;
    repeat (2) @(posedge clk);
    #1 n = 0;
    while (req_a === 1'b1 && n < 400) begin @(posedge clk) #1 n++; end
    chk(n > 250 && n < 264, 1'b1);
    // Fairness on: request stays up past threshold until the queue is full
    wr_reg(3'h2, 8'h02);
    slvl = 6'h0e;
    repeat (3) @(posedge clk);
    #1 chk(req_a, 1'b1);
    slvl = 6'h10;
    repeat (2) @(posedge clk);
    #1 chk(req_a, 1'b0);
  endtask
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_baud();
    t_fallback();
    t_legacy();
    t_dma();
    close_out();
  end
  initial begin
    #400000 failures++;
    close_out();
  end
endmodule
